/* hdl/los_pkg.sv */
// Package for the channel loss-of-signal status block: register map,
// field positions, reset values, line modes and detector timing counts.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package los_pkg;

    // Register byte offsets
    localparam logic [3:0] ALARM_STATUS_OFF = 4'h0;
    localparam logic [3:0] CONTROL_OFF      = 4'h4;
    localparam logic [3:0] INT_STATUS_OFF   = 4'h8;
    localparam logic [3:0] INT_MASK_OFF     = 4'hC;

    // Alarm status field positions (int status and mask share them)
    localparam int LOS_BIT     = 1;
    localparam int ANALOG_BIT  = 4;
    localparam int DIGITAL_BIT = 5;

    // Control field positions
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;

    // Reset values, read-zero value and writable alarm bit mask
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] INT_MASK_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO      = 8'h00;
    localparam logic [7:0] ALARM_MASK     = 8'h32;

    // Line rate selection
    typedef enum logic [1:0] {
        MODE_DS3  = 2'h0,
        MODE_STS1 = 2'h1,
        MODE_E3   = 2'h2
    } line_mode_type;

    // Digital detector: bit periods without pulses before loss
    localparam int DIG_DECLARE_BITS = 160;
    // Digital detector: clearing pulse density in percent
    localparam int DIG_CLEAR_PCT    = 33;
    // Bit periods over which pulse density is measured
    localparam int DENS_WINDOW_BITS = 32;
    // Pulses needed in one window, rounded up
    localparam int DENS_MIN_PULSES  =
        (DIG_CLEAR_PCT * DENS_WINDOW_BITS + 99) / 100;

    // E3 detector: zero run that declares loss, and clearing window
    localparam int E3_DECLARE_ZEROS = 32;
    localparam int E3_CLEAR_BITS    = 32;

    // Detector indications carried together
    typedef struct packed {
        logic digital;
        logic analog;
        logic combined;
    } alarm_type;

endpackage

/* hdl/los_status.sv */
// Loss-of-signal detection and alarm status for one receive channel.
// Assumes line_pulse_i and bit_strobe_i come from same-clock recovery
// logic; the analog comparator outputs are asynchronous pins.
//
// Operation
// - DS3/STS-1: digital detector declares loss after 160 pulseless bit periods.
// - DS3/STS-1: digital detector clears when pulse density reaches 33 percent.
// - Status bit 5 is read-only, shows digital loss declared.
// - DS3/STS-1: analog detector declares loss when amplitude drops below declare level.
// - DS3/STS-1: analog detector clears when amplitude rises above clear level.
// - Analog indication holds between the two thresholds, giving hysteresis.
// - Status bit 4 is read-only, shows analog loss declared.
// - Channel loss is OR of digital and analog declared states.
// - Combined channel loss reads as status bit 1.
// - E3 mode uses a zero-run loss detector feeding the combined bit.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps

module los_status
    import los_pkg::*;
#(
    parameter int DECLARE_BITS = los_pkg::DIG_DECLARE_BITS,
    parameter int WINDOW_BITS  = los_pkg::DENS_WINDOW_BITS,
    parameter int MIN_PULSES   = los_pkg::DENS_MIN_PULSES,
    parameter int E3_ZEROS     = los_pkg::E3_DECLARE_ZEROS,
    parameter int E3_WINDOW    = los_pkg::E3_CLEAR_BITS
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic [3:0]          adr_i,
    input  wire logic [31:0]         dat_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic                we_i,
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // Recovered line data, same clock
    input  wire logic                bit_strobe_i,
    input  wire logic                line_pulse_i,
    // Analog amplitude comparators, asynchronous
    input  wire logic                amp_below_declare_i,
    input  wire logic                amp_above_clear_i,
    // Alarm outputs
    output los_pkg::alarm_type       alarm_o,
    output logic                     irq_o
);
    import los_pkg::*;

    localparam int CW = $clog2(DECLARE_BITS + 1);
    localparam int WW = $clog2(WINDOW_BITS + 1);
    localparam int EW = $clog2(E3_ZEROS + 1);
    localparam int XW = $clog2(E3_WINDOW + 1);

    // Packs the alarm struct into the shared bit layout
    function automatic logic [7:0] pack_alarm(input alarm_type a);
        logic [7:0] w;
        w = READ_ZERO;
        w[DIGITAL_BIT] = a.digital;
        w[ANALOG_BIT]  = a.analog;
        w[LOS_BIT]     = a.combined;
        return w;
    endfunction

    // Register file and bus decode
    logic [7:0]        control_reg;
    logic [7:0]        int_status_reg;
    logic [7:0]        int_mask_reg;
    line_mode_type     mode;
    logic              e3_mode;
    logic              access;
    logic              wr_en;
    logic              rd_int_status;

    // Comparator synchronizer stages and accepted levels
    logic [1:0]        sync1_reg;
    logic [1:0]        sync2_reg;
    logic [1:0]        sync3_reg;
    logic              below_level_reg;
    logic              above_level_reg;

    // DS3/STS-1 detector state
    logic [CW-1:0]     zero_cnt_reg;
    logic [WW-1:0]     win_cnt_reg;
    logic [WW-1:0]     pulse_cnt_reg;
    logic              digital_reg;
    logic              analog_reg;

    // E3 detector state
    logic [EW-1:0]     e3_run_reg;
    logic [XW-1:0]     e3_win_reg;
    logic              e3_hit_reg;
    logic              e3_los_reg;
    logic              e3_zero_hit;

    // Alarm image and change events
    alarm_type         alarm_next;
    alarm_type         alarm_reg;
    logic [7:0]        events;

    assign mode          = line_mode_type'(control_reg[MODE_MSB:MODE_LSB]);
    assign e3_mode       = (mode == MODE_E3);
    assign access        = cyc_i && stb_i && !ack_o;
    assign wr_en         = access && we_i && sel_i[0];
    assign rd_int_status = access && !we_i && (adr_i == INT_STATUS_OFF);
    // Zero run at or past its length; a standing run keeps hitting, so a
    // dead line cannot clear E3 loss once the run counter saturates
    assign e3_zero_hit   = !line_pulse_i && (e3_run_reg >= EW'(E3_ZEROS - 1));

    // Three-stage comparator synchronizer; only stage 2 reads stage 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            sync3_reg <= 2'h0;
        end else begin
            sync1_reg <= {amp_above_clear_i, amp_below_declare_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A comparator change counts once stages 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            below_level_reg <= 1'b0;
            above_level_reg <= 1'b0;
        end else begin
            if (sync2_reg[0] == sync3_reg[0])
                below_level_reg <= sync3_reg[0];
            if (sync2_reg[1] == sync3_reg[1])
                above_level_reg <= sync3_reg[1];
        end
    end

    // Analog detector: two thresholds, state held in between
    always_ff @(posedge clk_i) begin
        if (rst_i || e3_mode) begin
            analog_reg <= 1'b0;
        end else if (below_level_reg) begin
            analog_reg <= 1'b1;
        end else if (above_level_reg) begin
            analog_reg <= 1'b0;
        end
    end

    // Digital detector: run of pulseless bit periods
    always_ff @(posedge clk_i) begin
        if (rst_i || e3_mode) begin
            zero_cnt_reg <= '0;
        end else if (bit_strobe_i) begin
            if (line_pulse_i)
                zero_cnt_reg <= '0;
            else if (zero_cnt_reg < CW'(DECLARE_BITS))
                zero_cnt_reg <= zero_cnt_reg + 1'b1;
        end
    end

    // Pulse density window; a full window with enough pulses clears loss
    always_ff @(posedge clk_i) begin
        if (rst_i || e3_mode) begin
            win_cnt_reg   <= '0;
            pulse_cnt_reg <= '0;
        end else if (bit_strobe_i) begin
            if (win_cnt_reg == WW'(WINDOW_BITS - 1)) begin
                win_cnt_reg   <= '0;
                pulse_cnt_reg <= '0;
            end else begin
                win_cnt_reg   <= win_cnt_reg + 1'b1;
                pulse_cnt_reg <= pulse_cnt_reg + WW'(line_pulse_i);
            end
        end
    end

    // Digital loss: declare on the 160th empty bit, clear on density
    always_ff @(posedge clk_i) begin
        if (rst_i || e3_mode) begin
            digital_reg <= 1'b0;
        end else if (bit_strobe_i) begin
            if (!line_pulse_i && zero_cnt_reg == CW'(DECLARE_BITS - 1))
                digital_reg <= 1'b1;
            else if (win_cnt_reg == WW'(WINDOW_BITS - 1) &&
                     pulse_cnt_reg + WW'(line_pulse_i) >= WW'(MIN_PULSES))
                digital_reg <= 1'b0;
        end
    end

    // E3 zero-run counter and window hit flag
    // Run counter saturates; the hit flag marks any run seen in this window before its last bit, which clears the flag
    always_ff @(posedge clk_i) begin
        if (rst_i || !e3_mode) begin
            e3_run_reg <= '0;
            e3_win_reg <= '0;
            e3_hit_reg <= 1'b0;
        end else if (bit_strobe_i) begin
            if (line_pulse_i)
                e3_run_reg <= '0;
            else if (e3_run_reg < EW'(E3_ZEROS))
                e3_run_reg <= e3_run_reg + 1'b1;
            if (e3_win_reg == XW'(E3_WINDOW - 1)) begin
                e3_win_reg <= '0;
                e3_hit_reg <= 1'b0;
            end else begin
                e3_win_reg <= e3_win_reg + 1'b1;
                if (e3_zero_hit)
                    e3_hit_reg <= 1'b1;
            end
        end
    end

    // E3 loss: zero run declares, a window free of such runs clears
    always_ff @(posedge clk_i) begin
        if (rst_i || !e3_mode) begin
            e3_los_reg <= 1'b0;
        end else if (bit_strobe_i) begin
            if (e3_zero_hit)
                e3_los_reg <= 1'b1;
            else if (e3_win_reg == XW'(E3_WINDOW - 1) && !e3_hit_reg)
                e3_los_reg <= 1'b0;
        end
    end

    // Combined state and change events
    always_comb begin
        alarm_next.digital  = digital_reg;
        alarm_next.analog   = analog_reg;
        alarm_next.combined = digital_reg || analog_reg || e3_los_reg;
        events = pack_alarm(alarm_next) ^ pack_alarm(alarm_reg);
    end

    // Registered alarm image seen by the bus and the change events
    always_ff @(posedge clk_i) begin
        if (rst_i)
            alarm_reg <= '0;
        else
            alarm_reg <= alarm_next;
    end

    // Control and mask writes, low byte lane only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_reg  <= CONTROL_RESET;
            int_mask_reg <= INT_MASK_RESET;
        end else if (wr_en) begin
            if (adr_i == CONTROL_OFF)
                control_reg <= dat_i[7:0];
            if (adr_i == INT_MASK_OFF)
                int_mask_reg <= dat_i[7:0] & ALARM_MASK;
        end
    end

    // Sticky change bits; read clears, a new change wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i)
            int_status_reg <= READ_ZERO;
        else if (rd_int_status)
            int_status_reg <= events;
        else
            int_status_reg <= int_status_reg | events;
    end

    // Level interrupt from flops
    always_ff @(posedge clk_i) begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |((rd_int_status ? events : (int_status_reg | events))
                       & int_mask_reg);
    end

    // Pin copy of the alarm image
    always_ff @(posedge clk_i) begin
        if (rst_i)
            alarm_o <= '0;
        else
            alarm_o <= alarm_next;
    end

    // Ack one cycle after the strobe, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= access;
    end

    // Read mux; unmapped offsets and writes answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (access && !we_i) begin
            case (adr_i)
                ALARM_STATUS_OFF: dat_o <= {24'h0, pack_alarm(alarm_reg)};
                CONTROL_OFF:      dat_o <= {24'h00_0000, control_reg};
                INT_STATUS_OFF:   dat_o <= {24'h00_0000, int_status_reg};
                INT_MASK_OFF:     dat_o <= {24'h00_0000, int_mask_reg};
                default:          dat_o <= 32'h0000_0000;
            endcase
        end else begin
            dat_o <= 32'h0000_0000;
        end
    end

endmodule // los_status

/* test/los_status_monitor.sv */
// Checker for the loss-of-signal status block, bound to its ports.
// Assumes the line mode changes only through bus writes to control.
`timescale 1ns/1ps
module los_status_monitor
    import los_pkg::*;
#(
    parameter int DECLARE_BITS = los_pkg::DIG_DECLARE_BITS
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic [3:0]          adr_i,
    input wire logic [31:0]         dat_i,
    input wire logic [3:0]          sel_i,
    input wire logic                we_i,
    input wire logic                cyc_i,
    input wire logic                stb_i,
    input wire logic [31:0]         dat_o,
    input wire logic                ack_o,
    input wire logic                bit_strobe_i,
    input wire logic                line_pulse_i,
    input wire logic                amp_below_declare_i,
    input wire logic                amp_above_clear_i,
    input wire los_pkg::alarm_type  alarm_o,
    input wire logic                irq_o
);
    logic [1:0]  mode_reg;
    logic [11:0] run_reg;
    wire         take = cyc_i && stb_i && !ack_o;
    wire         e3   = (mode_reg == 2'h2);
    // Mirror of the mode, so mode-bound checks know when to hold off
    always_ff @(posedge clk_i)
        if (rst_i) mode_reg <= 2'h0;
        else if (take && we_i && sel_i[0] && adr_i == CONTROL_OFF) mode_reg <= dat_i[1:0];
    // Empty bit run; any write restarts it, so it never runs ahead
    always_ff @(posedge clk_i)
        if (rst_i || (take && we_i)) run_reg <= 12'h000;
        else if (bit_strobe_i) run_reg <= line_pulse_i ? 12'h000 : run_reg + 12'h001;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next_cycle: assert property (take |=> ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_combined_or: assert property (alarm_o.digital || alarm_o.analog
        |-> alarm_o.combined)
        else $error("combined loss not set");
    a_digital_declare: assert property (bit_strobe_i && !line_pulse_i && !e3 &&
        run_reg == 12'(DECLARE_BITS - 1) |-> ##2 alarm_o.digital)
        else $error("digital loss late");
    a_analog_set: assert property ((amp_below_declare_i && !e3)[*8] |-> alarm_o.analog)
        else $error("analog loss not declared");
    a_analog_clear: assert property ((amp_above_clear_i && !amp_below_declare_i
        && !e3)[*8] |-> !alarm_o.analog)
        else $error("analog loss not cleared");
    a_analog_hold: assert property ((!amp_above_clear_i && !amp_below_declare_i
        && !e3)[*8] |-> $stable(alarm_o.analog))
        else $error("analog loss moved between thresholds");
    a_e3_no_detect: assert property (e3[*4] |-> !alarm_o.digital && !alarm_o.analog)
        else $error("ds3 detector active in e3");
    c_digital: cover property ($rose(alarm_o.digital));
    c_analog: cover property ($rose(alarm_o.analog));
    c_e3_loss: cover property (e3 && alarm_o.combined);
endmodule // los_status_monitor

bind los_status los_status_monitor #(.DECLARE_BITS(DECLARE_BITS)) mon (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .bit_strobe_i(bit_strobe_i), .line_pulse_i(line_pulse_i),
    .amp_below_declare_i(amp_below_declare_i), .amp_above_clear_i(amp_above_clear_i),
    .alarm_o(alarm_o), .irq_o(irq_o));

/* test/line_model.sv */
// Model of the recovered receive line and amplitude comparators.
// Assumes one bit every two clocks; comparators settle with delay.
`timescale 1ns/1ps
module line_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Scenario knobs: pulse spacing (0 none), amplitude 0 low 1 mid 2 high
    input  wire logic [3:0] gap_i,
    input  wire logic [1:0] amp_i,
    // Line side
    output logic            bit_strobe_o,
    output logic            line_pulse_o,
    output wire logic       below_o,
    output wire logic       above_o
);
    logic       ph_reg;
    logic [3:0] cnt_reg;
    // Bit strobe and pulses; data toggles between strobes as junk
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_reg       <= 1'b0;
            cnt_reg      <= 4'h0;
            bit_strobe_o <= 1'b0;
            line_pulse_o <= 1'b0;
        end else begin
            ph_reg       <= ~ph_reg;
            bit_strobe_o <= ph_reg;
            if (ph_reg) begin
                cnt_reg      <= (cnt_reg + 4'h1 >= gap_i) ? 4'h0 : cnt_reg + 4'h1;
                line_pulse_o <= (gap_i != 4'h0) && (cnt_reg == 4'h0);
            end else
                line_pulse_o <= ~line_pulse_o;
        end
    end
    // Comparators are async; delay keeps them off the clock edge
    assign #13 below_o = (amp_i == 2'h0);
    assign #13 above_o = (amp_i == 2'h2);
endmodule // line_model

/* test/los_status_tb.sv */
// Self-checking bench for the loss-of-signal status block.
// Assumes the line model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module los_status_tb;
    import los_pkg::*;
    logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, irq_o;
    logic        strobe, pulse, below, above;
    logic [3:0]  adr_i, sel_i, gap;
    logic [31:0] dat_i, dat_o;
    logic [1:0]  amp;
    alarm_type   alarm_o;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h00001FE6;
    int          err_total = 0;
    int          check_count = 0;

    los_status #(.DECLARE_BITS(16), .WINDOW_BITS(8), .MIN_PULSES(3), .E3_ZEROS(8),
        .E3_WINDOW(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
        .ack_o(ack_o), .bit_strobe_i(strobe), .line_pulse_i(pulse),
        .amp_below_declare_i(below), .amp_above_clear_i(above), .alarm_o(alarm_o),
        .irq_o(irq_o));
    line_model line (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .amp_i(amp),
        .bit_strobe_o(strobe), .line_pulse_o(pulse), .below_o(below), .above_o(above));

    // Clock at 25 MHz
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk_i);
    endtask

    // Classic cycle; expected read data noted first (writes read back 0)
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                      input logic [7:0] e);
        int n;
        n = 0;
        exp_q.push_back({24'h0, e});
        adr_i <= a;
        we_i  <= w;
        dat_i <= d;
        sel_i <= 4'h1;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 40) begin
            err_total++;
            stop_test();
        end
    endtask

    // Watcher: each ack takes the oldest note
    always @(posedge clk_i)
        if (ack_o === 1'b1) begin
            if (exp_q.size() == 0) chk("stray ack", 32'h0, 32'h1);
            else chk("read data", exp_q.pop_front(), dat_o);
        end

    initial begin
        rst_i = 1'b1;
        {we_i, cyc_i, stb_i} = 3'h0;
        {adr_i, sel_i, dat_i} = 40'h0;
        gap = 4'h1;
        amp = 2'h2;
        idle(20);
        rst_i <= 1'b0;
        idle(1);
        // Reset values, unmapped place, read-only status
        wb(CONTROL_OFF, 1'b0, 32'h0, CONTROL_RESET);
        wb(INT_MASK_OFF, 1'b0, 32'h0, INT_MASK_RESET);
        wb(4'h2, 1'b1, rnd(), READ_ZERO);
        wb(4'h2, 1'b0, 32'h0, READ_ZERO);
        wb(ALARM_STATUS_OFF, 1'b1, rnd(), 8'h00);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h00);
        wb(INT_MASK_OFF, 1'b1, 32'h000000FF, 8'h00);
        wb(INT_MASK_OFF, 1'b0, 32'h0, ALARM_MASK);
        $display("done: registers");
        // Digital detector in both modes, then low and sufficient density
        for (int m = 0; m < 2; m++) begin
            wb(CONTROL_OFF, 1'b1, 32'(m), 8'h00);
            gap <= 4'h0;
            idle(48);
            wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h22);
            chk("alarm pins", 32'h5, {29'h0, alarm_o});
            chk("irq raised", 32'h1, {31'h0, irq_o});
            wb(INT_STATUS_OFF, 1'b0, 32'h0, 8'h22);
            idle(2);
            chk("irq cleared", 32'h0, {31'h0, irq_o});
            gap <= 4'h4;
            idle(48);
            wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h22);
            gap <= 4'h2;
            idle(48);
            wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h00);
            wb(INT_STATUS_OFF, 1'b0, 32'h0, 8'h22);
        end
        $display("done: digital");
        // Analog detector, hysteresis band, interrupt masking
        amp <= 2'h0;
        idle(12);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h12);
        chk("alarm pins", 32'h3, {29'h0, alarm_o});
        wb(INT_MASK_OFF, 1'b1, 32'h0, 8'h00);
        idle(2);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wb(INT_MASK_OFF, 1'b1, 32'h000000FF, 8'h00);
        idle(2);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        amp <= 2'h1;
        idle(12);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h12);
        amp <= 2'h2;
        idle(12);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h00);
        amp <= 2'h1;
        idle(12);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h00);
        $display("done: analog");
        // Both detectors, then the E3 detector alone
        gap <= 4'h0;
        amp <= 2'h0;
        idle(48);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h32);
        chk("alarm pins", 32'h7, {29'h0, alarm_o});
        wb(CONTROL_OFF, 1'b1, 32'h2, 8'h00);
        idle(48);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h02);
        chk("alarm pins", 32'h1, {29'h0, alarm_o});
        gap <= 4'h1;
        amp <= 2'h2;
        idle(48);
        wb(ALARM_STATUS_OFF, 1'b0, 32'h0, 8'h00);
        wb(CONTROL_OFF, 1'b1, 32'h0, 8'h00);
        $display("done: e3");
        stop_test();
    end
endmodule // los_status_tb
